// file: rtl/lcfr_params.svh
// lcfr_params.svh: offsets, field positions, reset values and counts of the
// led driver register bank; included by the package and the design.
`ifndef LCFR_PARAMS_SVH
`define LCFR_PARAMS_SVH

// register positions on the serial interface
`define LCFR_OFS_CFG        1'h0
`define LCFR_OFS_FAULT      1'h1

// word and field widths
`define LCFR_WORD_W         24
`define LCFR_CHAN_N         16
`define LCFR_PAIR_N         8
`define LCFR_CRC_W          6

// configuration field positions
`define LCFR_CFG_DIAG_LSB   16
`define LCFR_CFG_DRAIN_LSB  0

// fault readback field positions
`define LCFR_FLT_PAIR_LSB   8
`define LCFR_FLT_TSD_BIT    7
`define LCFR_FLT_CMD_BIT    6
`define LCFR_FLT_CRC_LSB    0

// reset values
`define LCFR_CFG_RST        24'h00_0000
`define LCFR_FLT_RST        24'h00_0000

// checksum generator polynomial, low six bits, top term implied
`define LCFR_CRC_POLY       6'h2f
`define LCFR_CRC_INIT       6'h3f

`endif

// file: rtl/lcfr_pkg.sv
// lcfr_pkg: types shared by the led driver register bank.
// assumes lcfr_params.svh sits beside it on the include path.
`include "lcfr_params.svh"

package lcfr_pkg;

  // one serial word, configuration or readback
  typedef logic [`LCFR_WORD_W-1:0] lcfr_word_t;
  // one bit per channel
  typedef logic [`LCFR_CHAN_N-1:0] lcfr_chan_t;
  // one bit per diagnosed channel pair
  typedef logic [`LCFR_PAIR_N-1:0] lcfr_pair_t;
  // checksum field
  typedef logic [`LCFR_CRC_W-1:0]  lcfr_crc_t;

endpackage : lcfr_pkg

// file: rtl/lcfr_regbank.sv
// lcfr_regbank: configuration and fault readback registers of a
// 16-channel serial-shift led driver, with the shift chain on its own clock.
// assumes: the host stops the shift clock before pulsing the latch clock and
// leaves the shifted word still until the latch has been taken; all
// detector and control pins are asynchronous to core_clk.
//
// Contract
// - bits 16..18 pair sense pins 0,2,4; code uses bits 16..23, bit 16+k makes channel 2k+1 of pair k sense
// - diag bit high makes paired pin sense
// - bits 15..0 switch channel with same index
// - configuration write-only, resets to zero
// - readback 23..8 open over short per pair
// - open flag high on detected open
// - short flag high on detected short
// - open and short flags clear after readout
// - bit 7 thermal flag, read to clear
// - bit 6 command error, read to clear; code holds no flag, it sets the bit from the word taken at each latch
// - bits 5..0 checksum of configuration
// - readback at position 1, resets zero
// - clear input low resets every register; code leaves the shift and readback chains as they are
// - chip enable high holds registers default
// - latch clock loads storage, gated outputs
`timescale 1ns/1ns
`include "lcfr_params.svh"

module lcfr_regbank (
  // core clock and reset
  input  wire logic                clk_core,
  input  wire logic                arst_n,
  // serial link, shift clock domain
  input  wire logic                shift_clock,
  input  wire logic                serial_data_in,
  output logic                     serial_data_out,
  // latch and control pins
  input  wire logic                storage_latch_clock,
  input  wire logic                clear_all_n,
  input  wire logic                chip_enable_n,
  input  wire logic                group_a_output_enable_n,
  input  wire logic                group_b_output_enable_n,
  // fault detectors, one per pair, and die temperature
  input  wire lcfr_pkg::lcfr_pair_t led_open_det,
  input  wire lcfr_pkg::lcfr_pair_t led_short_det,
  input  wire logic                thermal_det,
  // channel drains, open drain, enable low while sinking
  output lcfr_pkg::lcfr_chan_t     channel_output_n_o,
  output lcfr_pkg::lcfr_chan_t     channel_output_n_oe_n,
  // paired pins working as sense inputs
  output lcfr_pkg::lcfr_pair_t     paired_sense_pin_n_en
);

  // fixed pair map: drain bit of pair k is channel 2k+1
  function automatic lcfr_pkg::lcfr_pair_t odd_drains(
    input lcfr_pkg::lcfr_word_t w
  );
    lcfr_pkg::lcfr_pair_t r;
    r = '0;
    for (int k = 0; k < `LCFR_PAIR_N; k++) begin
      r[k] = w[`LCFR_CFG_DRAIN_LSB + 2*k + 1];
    end
    return r;
  endfunction : odd_drains

  // diag field of a configuration word
  function automatic lcfr_pkg::lcfr_pair_t diag_bits(
    input lcfr_pkg::lcfr_word_t w
  );
    return w[`LCFR_CFG_DIAG_LSB +: `LCFR_PAIR_N];
  endfunction : diag_bits

  // serial checksum over the 24 configuration bits, msb first
  function automatic lcfr_pkg::lcfr_crc_t crc_of(
    input lcfr_pkg::lcfr_word_t w
  );
    lcfr_pkg::lcfr_crc_t c;
    logic                fb;
    c = `LCFR_CRC_INIT;
    for (int i = `LCFR_WORD_W - 1; i >= 0; i--) begin
      fb = c[`LCFR_CRC_W-1] ^ w[i];
      c  = {c[`LCFR_CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ `LCFR_CRC_POLY;
      end
    end
    return c;
  endfunction : crc_of

  // ---------------------------------------------------------------
  // core reset release
  // ---------------------------------------------------------------
  logic rst_s1_q;  // first release stage
  logic rst_n_q;   // released reset used by the core

  // assert at once, release after two edges
  always_ff @(posedge clk_core or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers, two flops each
  // ---------------------------------------------------------------
  localparam int SYNC_W = 5 + 2 * `LCFR_PAIR_N;

  logic [SYNC_W-1:0] pin_raw;   // pins in
  logic [SYNC_W-1:0] pin_s1_q;  // first stage, read by second only
  logic [SYNC_W-1:0] pin_s2_q;  // safe copy

  assign pin_raw = {storage_latch_clock, clear_all_n, chip_enable_n,
                    group_a_output_enable_n, group_b_output_enable_n,
                    led_open_det, led_short_det};

  // plain two-stage chain; pins idle low: clear asserted, chip and group enables active
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  logic                 thermal_s1_q;  // first stage
  logic                 thermal_s2_q;  // safe copy

  // thermal detector kept apart for readability
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      thermal_s1_q <= 1'b0;
      thermal_s2_q <= 1'b0;
    end else begin
      thermal_s1_q <= thermal_det;
      thermal_s2_q <= thermal_s1_q;
    end
  end

  // named views of the synchronised pins
  logic                 latch_s;
  logic                 clear_n_s;
  logic                 enable_n_s;
  logic                 grp_a_n_s;
  logic                 grp_b_n_s;
  lcfr_pkg::lcfr_pair_t open_s;
  lcfr_pkg::lcfr_pair_t short_s;

  assign latch_s    = pin_s2_q[SYNC_W-1];
  assign clear_n_s  = pin_s2_q[SYNC_W-2];
  assign enable_n_s = pin_s2_q[SYNC_W-3];
  assign grp_a_n_s  = pin_s2_q[SYNC_W-4];
  assign grp_b_n_s  = pin_s2_q[SYNC_W-5];
  assign open_s     = pin_s2_q[`LCFR_PAIR_N +: `LCFR_PAIR_N];
  assign short_s    = pin_s2_q[0 +: `LCFR_PAIR_N];

  // ---------------------------------------------------------------
  // latch edge and soft clear
  // ---------------------------------------------------------------
  logic latch_d1_q;  // previous latch level
  logic latch_ev;    // one-cycle latch strobe
  logic soft_clr;    // clear pin or standby

  // edge detector reads the safe copy only
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      latch_d1_q <= 1'b0;
    end else begin
      latch_d1_q <= latch_s;
    end
  end

  assign latch_ev = latch_s & ~latch_d1_q;
  // clear low or enable high holds configuration, flags and snapshot at default
  assign soft_clr = ~clear_n_s | enable_n_s;

  // ---------------------------------------------------------------
  // shift chain, shift clock domain
  // ---------------------------------------------------------------
  lcfr_pkg::lcfr_word_t shift_q;   // word being shifted in
  lcfr_pkg::lcfr_word_t rdbk_q;    // readback being shifted out
  logic                 reload_q;  // next edge loads readback
  lcfr_pkg::lcfr_word_t snap_q;    // core-held readback word

  // last 24 bits in stay in the chain; no clear here, latch filters it
  always_ff @(posedge shift_clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= `LCFR_CFG_RST;
    end else begin
      shift_q <= {shift_q[`LCFR_WORD_W-2:0], serial_data_in};
    end
  end

  // latch pin arms a reload; the clock may stand still until the frame
  always_ff @(posedge shift_clock or posedge storage_latch_clock
              or negedge arst_n) begin
    if (!arst_n) begin
      reload_q <= 1'b1;
    end else if (storage_latch_clock) begin
      reload_q <= 1'b1;
    end else begin
      reload_q <= 1'b0;
    end
  end

  // first frame edge loads the snapshot, later edges shift it out
  always_ff @(posedge shift_clock or negedge arst_n) begin
    if (!arst_n) begin
      rdbk_q <= `LCFR_FLT_RST;
    end else if (reload_q) begin
      rdbk_q <= snap_q;  // quasi-static: changed only at the latch or on clear or standby
    end else begin
      rdbk_q <= {rdbk_q[`LCFR_WORD_W-2:0], 1'b0};
    end
  end

  assign serial_data_out = rdbk_q[`LCFR_WORD_W-1];

  // ---------------------------------------------------------------
  // configuration register, write-only
  // ---------------------------------------------------------------
  lcfr_pkg::lcfr_word_t cfg_q;   // stored configuration
  lcfr_pkg::lcfr_word_t new_w;   // word taken at the latch

  // the shift clock is stopped here, so the word is stable
  assign new_w = shift_q;

  // latch copies the shifted word; defaults on clear or standby
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= `LCFR_CFG_RST;
    end else if (soft_clr) begin
      cfg_q <= `LCFR_CFG_RST;
    end else if (latch_ev) begin
      cfg_q <= new_w;
    end
  end

  // ---------------------------------------------------------------
  // sticky fault flags
  // ---------------------------------------------------------------
  lcfr_pkg::lcfr_pair_t open_q;    // open flags
  lcfr_pkg::lcfr_pair_t short_q;   // short flags
  logic                 tsd_q;     // thermal flag
  logic                 cmd_w;     // command error of the word at the latch
  lcfr_pkg::lcfr_pair_t diag_on;   // pairs in sense mode

  assign diag_on = diag_bits(cfg_q);

  // a detector only counts on a pair set up for sensing
  // set wins over the read clear taken at the latch
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      open_q  <= '0;
      short_q <= '0;
    end else if (soft_clr) begin
      open_q  <= '0;
      short_q <= '0;
    end else begin
      open_q  <= (latch_ev ? '0 : open_q) | (open_s & diag_on);
      short_q <= (latch_ev ? '0 : short_q) | (short_s & diag_on);
    end
  end

  // thermal flag, cleared once copied for readout
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tsd_q <= 1'b0;
    end else if (soft_clr) begin
      tsd_q <= 1'b0;
    end else begin
      tsd_q <= (tsd_q & ~latch_ev) | thermal_s2_q;
    end
  end

  // error judged on the word being latched; reports only that transfer
  // a register here would lag the snapshot by one latch, so the snapshot
  // takes the error straight from the word it is frozen with
  assign cmd_w = |(diag_bits(new_w) & odd_drains(new_w));

  // ---------------------------------------------------------------
  // readback snapshot
  // ---------------------------------------------------------------
  lcfr_pkg::lcfr_word_t flt_w;  // live readback view

  // open above short for each pair, pair 7 at the top
  always_comb begin
    flt_w = `LCFR_FLT_RST;
    for (int k = 0; k < `LCFR_PAIR_N; k++) begin
      flt_w[`LCFR_FLT_PAIR_LSB + 2*k + 1] = open_q[k];
      flt_w[`LCFR_FLT_PAIR_LSB + 2*k]     = short_q[k];
    end
    flt_w[`LCFR_FLT_TSD_BIT] = tsd_q;
    flt_w[`LCFR_FLT_CMD_BIT] = cmd_w;
    flt_w[`LCFR_FLT_CRC_LSB +: `LCFR_CRC_W] = crc_of(cfg_q);
  end

  // frozen at each latch; the flags it holds are then cleared above
  // the command error of the new word is known a cycle later, so the
  // snapshot takes it from the same word directly
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      snap_q <= `LCFR_FLT_RST;
    end else if (soft_clr) begin
      snap_q <= `LCFR_FLT_RST;
    end else if (latch_ev) begin
      snap_q <= flt_w;
    end
  end

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  logic                 gate_on;  // both groups enabled, die cool
  lcfr_pkg::lcfr_chan_t sw_on;    // switches commanded on

  assign gate_on = ~grp_a_n_s & ~grp_b_n_s & ~thermal_s2_q;

  // a pair in sense mode never sinks from its odd channel
  always_comb begin
    sw_on = cfg_q[`LCFR_CFG_DRAIN_LSB +: `LCFR_CHAN_N];
    for (int k = 0; k < `LCFR_PAIR_N; k++) begin
      if (diag_on[k]) begin
        sw_on[2*k+1] = 1'b0;
      end
    end
  end

  // registered pins: enable low sinks the drain, data stays low
  always_ff @(posedge clk_core or negedge rst_n_q) begin
    if (!rst_n_q) begin
      channel_output_n_o    <= '0;
      channel_output_n_oe_n <= '1;
      paired_sense_pin_n_en <= '0;
    end else begin
      channel_output_n_o    <= '0;
      channel_output_n_oe_n <= ~(sw_on & {`LCFR_CHAN_N{gate_on}});
      paired_sense_pin_n_en <= diag_on;
    end
  end

endmodule : lcfr_regbank

// file: sim/lcfr_host.sv
// lcfr_host: behavioural host on the serial link of the register bank.
// assumes the bench calls shift and latch one at a time.
`timescale 1ns/1ns

module lcfr_host (
  // link pins toward the device
  output logic                 shift_clock,
  output logic                 serial_data_in,
  output logic                 storage_latch_clock,
  // readback pin
  input  wire logic            serial_data_out
);
  lcfr_pkg::lcfr_word_t rb_word;  // readback of the last frame
  event                 rb_done;  // fires at the end of a frame

  // idle link: clock parked low outside frames
  initial begin
    shift_clock = 1'b0;
    serial_data_in = 1'b0;
    storage_latch_clock = 1'b0;
  end

  // lead bit then word msb first, readback sampled just after each rise but the last
  task automatic shift(input lcfr_pkg::lcfr_word_t w);
    logic [24:0] f;
    f = {~w[23], w};
    for (int i = 24; i >= 0; i--) begin
      serial_data_in = f[i];
      #7 shift_clock = 1'b1;
      #1 if (i > 0) rb_word[i-1] = serial_data_out;
      #7 shift_clock = 1'b0;
    end
    serial_data_in = ~serial_data_in;  // inverted: line left at the complement of the last bit shifted
    -> rb_done;
  endtask : shift

  // latch pulse five core cycles wide; clock already stopped
  task automatic latch;
    #40 storage_latch_clock = 1'b1;
    #50 storage_latch_clock = 1'b0;
  endtask : latch
endmodule : lcfr_host

// file: sim/lcfr_regbank_asserts.sv
// lcfr_regbank_asserts.sv: port checks of the led driver register bank.
// assumes the host leaves the shifted word still for ten core cycles after a latch.
`timescale 1ns/1ns

module lcfr_chk (
  // clocks and reset
  input wire logic                 clk_core,
  input wire logic                 arst_n,
  // link and control pins
  input wire logic                 shift_clock,
  input wire logic                 serial_data_in,
  input wire logic                 storage_latch_clock,
  input wire logic                 clear_all_n,
  input wire logic                 chip_enable_n,
  input wire logic                 group_a_output_enable_n,
  input wire logic                 group_b_output_enable_n,
  input wire logic                 thermal_det,
  // outputs under watch
  input wire lcfr_pkg::lcfr_chan_t channel_output_n_o,
  input wire lcfr_pkg::lcfr_chan_t channel_output_n_oe_n,
  input wire lcfr_pkg::lcfr_pair_t paired_sense_pin_n_en
);
  lcfr_pkg::lcfr_word_t sh_q;     // shadow of the shift chain
  logic [3:0]           age_q;    // core cycles since a config event
  lcfr_pkg::lcfr_pair_t odd_oe;   // enables of the diag-paired channels
  lcfr_pkg::lcfr_pair_t even_oe;  // enables of the plain channels
  logic                 cfg_ok;   // neither clear nor standby
  logic                 quiet;    // only config steers the drains

  assign cfg_ok = clear_all_n & ~chip_enable_n;
  assign quiet  = cfg_ok & ~group_a_output_enable_n & ~group_b_output_enable_n & ~thermal_det;

  // split the enables by pair position
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      odd_oe[k]  = channel_output_n_oe_n[2*k+1];
      even_oe[k] = channel_output_n_oe_n[2*k];
    end
  end

  // shadow chain, same edge as the device samples
  always_ff @(posedge shift_clock or negedge arst_n) begin
    if (!arst_n) sh_q <= 24'h000000;
    else sh_q <= {sh_q[22:0], serial_data_in};
  end

  // age since latch, clear or standby; saturates so it never wraps
  always_ff @(posedge clk_core or negedge arst_n) begin
    if (!arst_n) age_q <= 4'h0;
    else if (storage_latch_clock || !cfg_ok) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end

  default clocking @(posedge clk_core); endclocking
  default disable iff (!arst_n);

  property p_reset_idle;
    $rose(arst_n) |-> &channel_output_n_oe_n && paired_sense_pin_n_en == 8'h00;
  endproperty
  property p_drain_low;
    channel_output_n_o == 16'h0000;
  endproperty
  property p_sense_off;
    (paired_sense_pin_n_en & ~odd_oe) == 8'h00;
  endproperty
  property p_gate_off;
    (group_a_output_enable_n || group_b_output_enable_n)[*6] |-> &channel_output_n_oe_n;
  endproperty
  property p_clear;
    !clear_all_n[*8] |-> &channel_output_n_oe_n && paired_sense_pin_n_en == 8'h00;
  endproperty
  property p_standby;
    chip_enable_n[*8] |-> &channel_output_n_oe_n && paired_sense_pin_n_en == 8'h00;
  endproperty
  property p_sense_cfg;
    $rose(storage_latch_clock) ##1 cfg_ok[*8] |-> paired_sense_pin_n_en == sh_q[23:16];
  endproperty
  property p_drain_cfg;
    $rose(storage_latch_clock) ##1 quiet[*8] |->
      even_oe == ~{sh_q[14], sh_q[12], sh_q[10], sh_q[8], sh_q[6], sh_q[4], sh_q[2], sh_q[0]};
  endproperty
  property p_cfg_event;
    $changed(paired_sense_pin_n_en) |-> age_q < 4'ha;
  endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  a_drain_low: assert property (p_drain_low) else $error("drain data not low");
  a_sense_off: assert property (p_sense_off) else $error("sense pair channel on");
  a_gate_off: assert property (p_gate_off) else $error("drain on with gate high");
  a_clear: assert property (p_clear) else $error("clear left state");
  a_standby: assert property (p_standby) else $error("standby left state");
  a_sense_cfg: assert property (p_sense_cfg) else $error("sense enables wrong");
  a_drain_cfg: assert property (p_drain_cfg) else $error("drain enables wrong");
  a_cfg_event: assert property (p_cfg_event) else $error("config moved alone");

  c_latch: cover property ($rose(storage_latch_clock) ##1 quiet[*8]);
  c_clear: cover property (!clear_all_n[*8]);
  c_standby: cover property (chip_enable_n[*8]);
endmodule : lcfr_chk

bind lcfr_regbank lcfr_chk u_lcfr_chk (
  .clk_core, .arst_n, .shift_clock, .serial_data_in, .storage_latch_clock, .clear_all_n,
  .chip_enable_n, .group_a_output_enable_n, .group_b_output_enable_n, .thermal_det,
  .channel_output_n_o, .channel_output_n_oe_n, .paired_sense_pin_n_en);

// file: sim/lcfr_regbank_bench.sv
// lcfr_regbank_bench: self-checking bench of the led driver register bank.
// assumes lcfr_host drives the link and the checker is bound in.
`timescale 1ns/1ns
`include "lcfr_params.svh"

module lcfr_regbank_bench;
  logic                 clk_core = 1'b0;       // core clock
  logic                 arst_n = 1'b0;         // async reset
  logic                 clear_all_n = 1'b1;    // clear pin
  logic                 chip_enable_n = 1'b0;  // standby pin
  logic                 ga = 1'b0;             // group a gate
  logic                 gb = 1'b0;             // group b gate
  logic                 thermal_det = 1'b0;    // over temperature
  lcfr_pkg::lcfr_pair_t led_open_det = 8'h00;  // open detectors
  lcfr_pkg::lcfr_pair_t led_short_det = 8'h00; // short detectors
  wire                  shift_clock;
  wire                  serial_data_in;
  wire                  storage_latch_clock;
  wire                  serial_data_out;
  lcfr_pkg::lcfr_chan_t oe_n;
  lcfr_pkg::lcfr_pair_t sense_en;
  lcfr_pkg::lcfr_word_t exp_q[$];              // notes of readbacks to come
  lcfr_pkg::lcfr_word_t cfg = 24'h000000;      // config in force
  lcfr_pkg::lcfr_word_t w;
  lcfr_pkg::lcfr_word_t dir [3] = '{24'h00ffff, 24'hff0000, 24'hffffff};
  int                   fail_count = 0;
  int                   checks_done = 0;
  integer               seed = 32'h58e7f297;

  always #5 clk_core = ~clk_core;

  lcfr_regbank u_lcfr_regbank (
    .clk_core, .arst_n, .shift_clock, .serial_data_in, .serial_data_out,
    .storage_latch_clock, .clear_all_n, .chip_enable_n,
    .group_a_output_enable_n(ga), .group_b_output_enable_n(gb),
    .led_open_det, .led_short_det, .thermal_det, .channel_output_n_o(),
    .channel_output_n_oe_n(oe_n), .paired_sense_pin_n_en(sense_en));

  lcfr_host u_lcfr_host (.shift_clock, .serial_data_in, .storage_latch_clock, .serial_data_out);

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // inputs move one ns after the core edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_core);
    #1;
  endtask : tick

  // checksum model, msb first over the word
  function automatic logic [5:0] crc6(input logic [23:0] v);
    logic [5:0] c;
    c = `LCFR_CRC_INIT;
    for (int i = 23; i >= 0; i--) c = {c[4:0], 1'b0} ^ ((c[5] ^ v[i]) ? `LCFR_CRC_POLY : 6'h00);
    return c;
  endfunction : crc6

  // one write with detectors live, then latch and output checks
  task automatic step(input lcfr_pkg::lcfr_word_t v, input logic rnd);
    logic [31:0]          r;
    lcfr_pkg::lcfr_chan_t on;
    lcfr_pkg::lcfr_word_t fl;
    r = $random(seed);
    ga = r[0] & r[1];
    gb = r[2] & r[3];
    led_open_det = rnd ? r[15:8] : 8'h00;
    led_short_det = rnd ? r[23:16] : 8'h00;
    thermal_det = rnd & r[26] & r[27];
    on = v[15:0];
    fl = {16'h0000, thermal_det, 1'b0, crc6(cfg)};
    for (int k = 0; k < 8; k++) begin
      fl[2*k+9 -: 2] = {led_open_det[k], led_short_det[k]} & {2{cfg[16+k]}};
      fl[6] = fl[6] | (v[16+k] & v[2*k+1]);
      if (v[16+k]) on[2*k+1] = 1'b0;
    end
    u_lcfr_host.shift(v);
    tick(1);
    led_open_det = 8'h00;
    led_short_det = 8'h00;
    thermal_det = 1'b0;
    tick(6);
    u_lcfr_host.latch();
    exp_q.push_back(fl);
    cfg = v;
    tick(10);
    check({8'h00, oe_n}, {8'h00, (ga | gb) ? 16'hffff : ~on});
    check({16'h0000, sense_en}, {16'h0000, v[23:16]});
  endtask : step

  // kind 0: clear pin, kind 1: standby
  task automatic wipe(input logic kind);
    ga = 1'b0;
    gb = 1'b0;
    clear_all_n = kind;
    chip_enable_n = kind;
    tick(10);
    clear_all_n = 1'b1;
    chip_enable_n = 1'b0;
    tick(10);
    check({8'h00, oe_n}, 24'h00ffff);
    check({16'h0000, sense_en}, 24'h000000);
    cfg = 24'h000000;
    if (exp_q.size() > 0) exp_q[$] = 24'h000000;
  endtask : wipe

  // readback monitor: oldest note against what the host shifted out
  always @(u_lcfr_host.rb_done) begin
    if (exp_q.size() > 0) check(u_lcfr_host.rb_word, exp_q.pop_front());
  end

  initial begin
    repeat (16) @(posedge clk_core);
    #1 arst_n = 1'b1;
    tick(4);
    for (int i = 0; i < 24; i++) begin
      w = (i < 3) ? dir[i] : 24'($random(seed));
      step(w, 1'b1);
      if (i == 4 || i == 9) wipe(i == 9);
    end
    step(24'h000000, 1'b0);
    step(24'h000000, 1'b0);
    end_of_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_core);
    fail_count++;
    end_of_test();
  end
endmodule : lcfr_regbank_bench
